// File: rtl/sfd_pkg.sv
// Constants and register map for the stepper fault diagnostics block
// Operation
// - Hot warning lowers fault flag, nothing else
// - Overtemperature lowers flag and disables bridge outputs
// - Low-side sense overvoltage while on flags overcurrent
// - Confirm short after continuous delay; flag if selected
// - Confirmed short keeps output off until reset
// - High-side overcurrent while that FET conducts
// - High and low short together means shorted load
// - Delay timer starts, latches, or resets quietly
// - Step edge, clear pulse or write clears short
// - Persistent short repeats enable then disable cycle
// - Open-load monitoring only when DAC above 31
// - Limit choice bit selects open-load current level
// - Ignore open-load comparison during blank time
// - Open load after more than 15 missed cycles
// - Keep driving; clear open load on current or DAC
// - Per-phase PWM cycle counter during current rise
// - Compare against opposite phase; flag stall if larger
// - Confirm delay 2 us default, 4 us selected
// - Open-load level 20 percent default, 30 selected
// - Five-bit count difference; zero disables stall detection
// - Blank time 3.5 us default, 1.5 us selected
`default_nettype none

package sfd_pkg;

	// Clock and times, all in nanoseconds
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SCT_SHORT_NS   = 2000;
	localparam int SCT_LONG_NS    = 4000;
	localparam int BLANK_LONG_NS  = 3500;
	localparam int BLANK_SHORT_NS = 1500;
	// Least times round up to whole cycles
	localparam int SCT_SHORT_CYC   = (SCT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCT_LONG_CYC    = (SCT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_LONG_CYC  = (BLANK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Timer width, confirm last counts and blank load values
	localparam int TMR_W = 10;
	localparam logic [TMR_W-1:0] SCT_SHORT_LAST = TMR_W'(SCT_SHORT_CYC - 1);
	localparam logic [TMR_W-1:0] SCT_LONG_LAST  = TMR_W'(SCT_LONG_CYC - 1);
	localparam logic [TMR_W-1:0] BLANK_LONG_LD  = TMR_W'(BLANK_LONG_CYC);
	localparam logic [TMR_W-1:0] BLANK_SHORT_LD = TMR_W'(BLANK_SHORT_CYC);

	// Bridge and open-load sizes
	localparam int NUM_FET   = 8;
	localparam int NUM_PHASE = 2;
	localparam int DAC_W     = 6;
	localparam int OL_W      = 5;
	localparam logic [DAC_W-1:0] DAC_OL_MIN  = 6'h1f;
	localparam logic [OL_W-1:0]  OL_CYCLES   = 5'h0f;
	localparam logic [OL_W-1:0]  OL_CNT_MAX  = 5'h10;

	// Register byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h08;

	// Configuration fields
	localparam int CFG_BLANK  = 0;
	localparam int CFG_DELAY  = 1;
	localparam int CFG_OLSEL  = 2;
	localparam int CFG_CD_LSB = 4;
	localparam int CFG_CD_W   = 5;
	localparam int CFG_FLAG   = 12;

endpackage

`default_nettype wire

// File: rtl/sfd_top.sv
// Fault diagnostics: temperature, shorts, open load, stall, APB registers
`default_nettype none

module sfd_top
	import sfd_pkg::*;
#(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input  wire logic                             mclk,
	input  wire logic                             reset_n,
	// APB slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [ADDR_W-1:0]                paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// Temperature comparators
	input  wire logic                             hotWarn,
	input  wire logic                             overTemp,
	// Bridge FET state and overcurrent comparators
	input  wire logic [3:0]                       lowSideOn,
	input  wire logic [3:0]                       lowSideSenseOver,
	input  wire logic [3:0]                       highSideOn,
	input  wire logic [3:0]                       highSideOverCurrent,
	// Phase regulator signals
	input  wire logic [NUM_PHASE-1:0][DAC_W-1:0]  phaseDac,
	input  wire logic [NUM_PHASE-1:0]             pwmStart,
	input  wire logic [NUM_PHASE-1:0]             aboveOl20,
	input  wire logic [NUM_PHASE-1:0]             aboveOl30,
	input  wire logic [NUM_PHASE-1:0]             riseStart,
	input  wire logic [NUM_PHASE-1:0]             riseEnd,
	// Host pins
	input  wire logic                             stepIn,
	input  wire logic                             activeLowClearN,
	// Fault outputs
	output logic                                  faultOutputPinN,
	output logic                                  motorBlockedFaultN,
	output logic      [NUM_PHASE-1:0]             bridgeEnable,
	output logic      [NUM_PHASE-1:0]             openLoad,
	output logic      [NUM_PHASE-1:0]             shortedLoad
);

	typedef struct packed {
		logic                                blankSelect;
		logic                                overcurrentDelaySelect;
		logic                                openLoadLimitChoice;
		logic                                flagSelect;
		logic [CFG_CD_W-1:0]                 pwmCountDifference;
		logic                                stepPrev;
		logic [NUM_FET-1:0][TMR_W-1:0]       ocCnt;
		logic [NUM_FET-1:0]                  shortLat;
		logic [NUM_PHASE-1:0][TMR_W-1:0]     blankCnt;
		logic [NUM_PHASE-1:0]                olSeen;
		logic [NUM_PHASE-1:0][OL_W-1:0]      olCnt;
		logic [NUM_PHASE-1:0]                openLoad;
		logic [NUM_PHASE-1:0]                rising;
		logic [NUM_PHASE-1:0][CNT_W-1:0]     pwmCnt;
		logic [NUM_PHASE-1:0][CNT_W-1:0]     pwmPrev;
		logic                                stall;
		logic [NUM_PHASE-1:0]                bridgeEn;
		logic [NUM_PHASE-1:0]                shortedLoad;
		logic                                faultN;
		logic [31:0]                         rdata;
	} sfd_state_type;

	sfd_state_type st;
	sfd_state_type next_st;

	logic [NUM_FET-1:0] overCurrent;
	logic               apbSetup;
	logic               apbAccess;
	logic               cfgWrite;
	logic               addrMapped;
	logic               faultReset;
	logic [TMR_W-1:0]   confirmLast;
	logic [TMR_W-1:0]   blankLoad;

	// Saturating increment, so a long rise never wraps to a small count
	function automatic logic [CNT_W-1:0] incSat(input logic [CNT_W-1:0] v);
		logic [CNT_W-1:0] r;
		r = v;
		if (v != {CNT_W{1'b1}}) begin
			r = v + 1'b1;
		end
		return r;
	endfunction

	// Magnitude of a difference of two counts
	function automatic logic [CNT_W-1:0] absDiff(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		logic [CNT_W-1:0] r;
		r = (a > b) ? (a - b) : (b - a);
		return r;
	endfunction

	// Overcurrent sources: low sides in [3:0], high sides in [7:4]
	// sense over only counts while FET on
	// high-side current only while FET on
	assign overCurrent = {highSideOn & highSideOverCurrent, lowSideOn & lowSideSenseOver};

	// APB decode; zero wait states, so pready stays high
	assign apbSetup   = psel && !penable;
	assign apbAccess  = psel && penable;
	assign addrMapped = (paddr == ADDR_CONFIG) || (paddr == ADDR_STATUS) || (paddr == ADDR_COUNT);
	assign cfgWrite   = apbAccess && pwrite && (paddr == ADDR_CONFIG);
	assign pready     = 1'b1;
	assign pslverr    = apbAccess && (!addrMapped || (pwrite && paddr != ADDR_CONFIG));

	// step edge, clear pulse or write
	assign faultReset = (stepIn && !st.stepPrev) || !activeLowClearN || cfgWrite;

	assign confirmLast = st.overcurrentDelaySelect ? SCT_LONG_LAST : SCT_SHORT_LAST;
	assign blankLoad   = st.blankSelect ? BLANK_SHORT_LD : BLANK_LONG_LD;

	// Next state of the whole block
	always_comb begin
		logic [NUM_PHASE-1:0] lsHit;
		logic [NUM_PHASE-1:0] hsHit;
		logic                 olActive;
		logic                 olAbove;
		logic                 olEval;
		logic                 olMiss;
		int                   q;
		lsHit    = '0;
		hsHit    = '0;
		olActive = 1'b0;
		olAbove  = 1'b0;
		olEval   = 1'b0;
		olMiss   = 1'b0;
		q        = 0;
		next_st  = st;
		next_st.stepPrev = stepIn;

		// Configuration write; reserved bits are dropped
		if (cfgWrite) begin
			next_st.blankSelect            = pwdata[CFG_BLANK];
			next_st.overcurrentDelaySelect = pwdata[CFG_DELAY];
			next_st.openLoadLimitChoice    = pwdata[CFG_OLSEL];
			next_st.flagSelect             = pwdata[CFG_FLAG];
			next_st.pwmCountDifference     = pwdata[CFG_CD_LSB +: CFG_CD_W];
		end

		// Per-source short confirmation timers
		for (int i = 0; i < NUM_FET; i++) begin
			if (faultReset) begin
				// clear lets a lasting short reconfirm
				next_st.shortLat[i] = 1'b0;
				next_st.ocCnt[i]    = '0;
			end else if (st.shortLat[i]) begin
				next_st.ocCnt[i] = '0;
			end else if (overCurrent[i]) begin
				// each source timed on its own
				if (st.ocCnt[i] >= confirmLast) begin
					next_st.shortLat[i] = 1'b1;
				end else begin
					next_st.ocCnt[i] = st.ocCnt[i] + 1'b1;
				end
			end else begin
				next_st.ocCnt[i] = '0;
			end
			if (i < NUM_FET / 2) begin
				lsHit[i / 2] = lsHit[i / 2] | next_st.shortLat[i];
			end else begin
				hsHit[(i - NUM_FET / 2) / 2] = hsHit[(i - NUM_FET / 2) / 2] | next_st.shortLat[i];
			end
		end

		// Bridge enables and shorted-load report per phase
		for (int p = 0; p < NUM_PHASE; p++) begin
			next_st.bridgeEn[p]    = !overTemp && !lsHit[p] && !hsHit[p];
			next_st.shortedLoad[p] = lsHit[p] && hsHit[p];
		end

		// Open-load watch per phase
		for (int p = 0; p < NUM_PHASE; p++) begin
			olActive = phaseDac[p] > DAC_OL_MIN;
			olAbove  = st.openLoadLimitChoice ? aboveOl30[p] : aboveOl20[p];
			olEval   = (st.blankCnt[p] == '0);
			if (pwmStart[p]) begin
				next_st.blankCnt[p] = blankLoad;
			end else if (!olEval) begin
				next_st.blankCnt[p] = st.blankCnt[p] - 1'b1;
			end
			olMiss = pwmStart[p] && !st.olSeen[p] && !(olEval && olAbove);
			if (!olActive) begin
				// DAC below 32 clears at once
				next_st.olCnt[p]    = '0;
				next_st.olSeen[p]   = 1'b0;
				next_st.openLoad[p] = 1'b0;
			end else begin
				if (olEval && olAbove) begin
					next_st.olSeen[p]   = 1'b1;
					next_st.olCnt[p]    = '0;
					next_st.openLoad[p] = 1'b0;
				end
				if (pwmStart[p]) begin
					next_st.olSeen[p] = 1'b0;
				end
				if (olMiss) begin
					if (st.olCnt[p] != OL_CNT_MAX) begin
						next_st.olCnt[p] = st.olCnt[p] + 1'b1;
					end
					if (st.olCnt[p] >= OL_CYCLES) begin
						next_st.openLoad[p] = 1'b1;
					end
				end
			end
		end

		// Stall watch: PWM cycles counted per current rise
		for (int p = 0; p < NUM_PHASE; p++) begin
			q = NUM_PHASE - 1 - p;
			if (riseStart[p]) begin
				next_st.rising[p] = 1'b1;
				next_st.pwmCnt[p] = '0;
			end else if (st.rising[p] && pwmStart[p]) begin
				next_st.pwmCnt[p] = incSat(st.pwmCnt[p]);
			end
			if (riseEnd[p] && st.rising[p] && !riseStart[p]) begin
				next_st.rising[p]  = 1'b0;
				next_st.pwmPrev[p] = st.pwmCnt[p];
				// compare with opposite phase previous rise
				next_st.stall = absDiff(st.pwmCnt[p], st.pwmPrev[q]) > CNT_W'(st.pwmCountDifference);
			end
		end
		// zero margin turns stall detection off
		if (next_st.pwmCountDifference == '0) begin
			next_st.stall = 1'b0;
		end

		// Fault flag: shorts gated by the flag selection
		// hot warning only lowers the flag
		// confirmed short drives flag when selected
		next_st.faultN = !(hotWarn || overTemp || (|next_st.openLoad) || next_st.stall ||
			(next_st.flagSelect && (|next_st.shortLat)));

		// Read data captured in setup so it is stable in access
		if (apbSetup && !pwrite) begin
			next_st.rdata = '0;
			case (paddr)
				ADDR_CONFIG: begin
					next_st.rdata[CFG_BLANK]                = st.blankSelect;
					next_st.rdata[CFG_DELAY]                = st.overcurrentDelaySelect;
					next_st.rdata[CFG_OLSEL]                = st.openLoadLimitChoice;
					next_st.rdata[CFG_FLAG]                 = st.flagSelect;
					next_st.rdata[CFG_CD_LSB +: CFG_CD_W]   = st.pwmCountDifference;
				end
				ADDR_STATUS: begin
					next_st.rdata = 32'({st.bridgeEn, st.shortedLoad, st.stall, st.openLoad,
						st.shortLat, overTemp, hotWarn});
				end
				ADDR_COUNT: begin
					next_st.rdata = 32'({st.pwmPrev[1], st.pwmPrev[0]});
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
	end

	// State register; reset takes constants only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st            <= '0;
			st.flagSelect <= 1'b1;
			st.bridgeEn   <= '1;
			st.faultN     <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign prdata             = st.rdata;
	assign faultOutputPinN    = st.faultN;
	assign motorBlockedFaultN = !st.stall;
	assign bridgeEnable       = st.bridgeEn;
	assign openLoad           = st.openLoad;
	assign shortedLoad        = st.shortedLoad;

	// Checks on temperature handling
	AST_HOT_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
		hotWarn |=> !faultOutputPinN) else $error("hot warning did not lower fault flag");
	AST_OT_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
		overTemp |=> (bridgeEnable == '0) && !faultOutputPinN) else $error("overtemperature left bridge on");

	// Checks on short confirmation and retry
	AST_SHORT_CAUSE: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(st.shortLat[0]) |-> $past(overCurrent[0]) && $past(st.ocCnt[0]) >= SCT_SHORT_LAST)
		else $error("short latched without full delay");
	AST_TIMER_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
		!overCurrent[0] |=> st.ocCnt[0] == '0) else $error("confirm timer kept counting");
	AST_SHORT_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
		st.shortLat[0] && !faultReset |=> st.shortLat[0] && !bridgeEnable[0])
		else $error("latched short released or output on");
	AST_RETRY: assert property (@(posedge mclk) disable iff (!reset_n)
		faultReset |=> st.shortLat == '0) else $error("fault reset did not clear shorts");
	AST_SHORT_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
		(|next_st.shortLat) && next_st.flagSelect |=> !faultOutputPinN) else $error("short not on fault pin");
	AST_SHORTED_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
		st.shortedLoad[1] == ((|st.shortLat[3:2]) && (|st.shortLat[7:6])))
		else $error("shorted load report wrong");

	// Checks on open load and stall
	AST_OL_FLOOR: assert property (@(posedge mclk) disable iff (!reset_n)
		phaseDac[0] <= DAC_OL_MIN |=> !openLoad[0]) else $error("open load with low DAC");
	AST_OL_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(openLoad[0]) |-> $past(st.olCnt[0]) >= OL_CYCLES) else $error("open load too early");
	AST_STALL_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
		st.pwmCountDifference == '0 |-> motorBlockedFaultN) else $error("stall with detection off");

	// Checks on source gating and on flags that must stand still
	AST_HS_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
		!highSideOn[0] |=> st.ocCnt[4] == '0) else $error("high-side timer ran while FET off");
	AST_OL_DRIVE: assert property (@(posedge mclk) disable iff (!reset_n)
		openLoad[0] && !overTemp && !(|next_st.shortLat[1:0]) && !(|next_st.shortLat[5:4])
		|=> bridgeEnable[0]) else $error("open load turned the bridge off");
	AST_STALL_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
		!(|riseEnd) && !cfgWrite |=> $stable(motorBlockedFaultN)) else $error("stall flag moved without a compare");

endmodule

`default_nettype wire

// File: sim/sfd_host_model.sv
// Host side model: step and clear pins toward the diagnostics block
`default_nettype none

module sfd_host_model (
	// Clock
	input  wire logic mclk,
	// Requests from the bench
	input  wire logic stepReq,
	input  wire logic clearReq,
	// Pins toward the device
	output logic      stepIn,
	output logic      activeLowClearN
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] stepCnt = 2'h0;
	logic [1:0] clearCnt = 2'h0;

	// Pins held two cycles so the device sees a clean edge
	// step edge or clear pulse as reset
	always_ff @(posedge mclk) begin
		stepCnt  <= stepReq ? 2'h2 : (stepCnt != 2'h0 ? stepCnt - 2'h1 : 2'h0);
		clearCnt <= clearReq ? 2'h2 : (clearCnt != 2'h0 ? clearCnt - 2'h1 : 2'h0);
	end

	// Pin levels, clear is active low
	assign stepIn          = (stepCnt != 2'h0);
	assign activeLowClearN = (clearCnt == 2'h0);
endmodule

`default_nettype wire

// File: sim/tb_sfd_top.sv
// Self-checking bench for the fault diagnostics block
`default_nettype none

module tb_sfd_top
	import sfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Row: config, temperature, overcurrent masks, cycles, expected outputs
	typedef struct packed {
		logic [15:0] cfg;
		logic [1:0]  temp;
		logic [3:0]  low;
		logic [3:0]  high;
		logic [9:0]  cyc;
		logic [1:0]  bridge;
		logic        fault;
		logic [1:0]  sl;
	} sfd_row_type;

	localparam sfd_row_type ROWS [7] = '{
		'{16'h1000, 2'h0, 4'h0, 4'h0, 10'd1, 2'h3, 1'b1, 2'h0},
		'{16'h1000, 2'h1, 4'h0, 4'h0, 10'd1, 2'h3, 1'b0, 2'h0},
		'{16'h1000, 2'h2, 4'h0, 4'h0, 10'd1, 2'h0, 1'b0, 2'h0},
		'{16'h1000, 2'h0, 4'h1, 4'h0, 10'd200, 2'h2, 1'b0, 2'h0},
		'{16'h1002, 2'h0, 4'h0, 4'h4, 10'd400, 2'h1, 1'b0, 2'h0},
		'{16'h0000, 2'h0, 4'h8, 4'h4, 10'd200, 2'h1, 1'b1, 2'h2},
		'{16'h1000, 2'h0, 4'h2, 4'h1, 10'd200, 2'h2, 1'b0, 2'h1}
	};

	logic                            mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic                            hotWarn, overTemp, stepIn, activeLowClearN, stepReq, clearReq;
	logic                            faultOutputPinN, motorBlockedFaultN;
	logic [ADDR_W-1:0]               paddr;
	logic [31:0]                     pwdata, prdata, rd;
	logic [3:0]                      lowSideOn, lowSideSenseOver, highSideOn, highSideOverCurrent;
	logic [NUM_PHASE-1:0][DAC_W-1:0] phaseDac;
	logic [NUM_PHASE-1:0]            pwmStart, aboveOl20, aboveOl30, riseStart, riseEnd;
	logic [NUM_PHASE-1:0]            bridgeEnable, openLoad, shortedLoad;
	int                              failures, n_tests, n;

	sfd_top #(.CNT_W(8)) i_sfd_top (
		.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hotWarn(hotWarn), .overTemp(overTemp), .lowSideOn(lowSideOn), .lowSideSenseOver(lowSideSenseOver),
		.highSideOn(highSideOn), .highSideOverCurrent(highSideOverCurrent), .phaseDac(phaseDac),
		.pwmStart(pwmStart), .aboveOl20(aboveOl20), .aboveOl30(aboveOl30), .riseStart(riseStart),
		.riseEnd(riseEnd), .stepIn(stepIn), .activeLowClearN(activeLowClearN),
		.faultOutputPinN(faultOutputPinN), .motorBlockedFaultN(motorBlockedFaultN),
		.bridgeEnable(bridgeEnable), .openLoad(openLoad), .shortedLoad(shortedLoad)
	);

	sfd_host_model i_sfd_host_model (
		.mclk(mclk), .stepReq(stepReq), .clearReq(clearReq),
		.stepIn(stepIn), .activeLowClearN(activeLowClearN)
	);

	// Clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Watchdog, run needs about 17000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		results();
	end

	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Overcurrent on the masked FETs, conducting as well
	task automatic setOc(input logic [3:0] lo, input logic [3:0] hi);
		lowSideOn           <= lo;
		lowSideSenseOver    <= lo;
		highSideOn          <= hi;
		highSideOverCurrent <= hi;
	endtask

	// Bounded wait for a bridge enable pattern, cycles in n
	task automatic waitBridge(input logic [1:0] v);
		n = 0;
		while (bridgeEnable !== v && n < 1000) begin
			@(posedge mclk);
			#1 n++;
		end
	endtask

	// Drop every cause, pulse the clear pin, expect a clean state
	task automatic releaseFaults();
		@(posedge mclk);
		{overTemp, hotWarn} <= 2'h0;
		setOc(4'h0, 4'h0);
		clearReq <= 1'b1;
		@(posedge mclk);
		clearReq <= 1'b0;
		repeat (4) @(posedge mclk);
		#1 check(bridgeEnable, 2'h3);
		check(faultOutputPinN, 1'b1);
	endtask

	// PWM start pulses with idle gaps between them
	task automatic pulse(input int ph, input int cnt, input int gap);
		repeat (cnt) begin
			@(posedge mclk);
			pwmStart[ph] <= 1'b1;
			@(posedge mclk);
			pwmStart[ph] <= 1'b0;
			repeat (gap) @(posedge mclk);
		end
	endtask

	// One current rise of a phase holding cnt PWM cycles
	task automatic rise(input int ph, input int cnt);
		@(posedge mclk);
		riseStart[ph] <= 1'b1;
		@(posedge mclk);
		riseStart[ph] <= 1'b0;
		pulse(ph, cnt, 0);
		@(posedge mclk);
		riseEnd[ph] <= 1'b1;
		@(posedge mclk);
		riseEnd[ph] <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	// Main sequence
	initial begin
		{reset_n, psel, penable, pwrite, hotWarn, overTemp, stepReq, clearReq} = 8'h0;
		paddr = '0;
		pwdata = '0;
		{lowSideOn, lowSideSenseOver, highSideOn, highSideOverCurrent} = 16'h0;
		phaseDac = '0;
		{pwmStart, aboveOl20, aboveOl30, riseStart, riseEnd} = 10'h0;
		failures = 0;
		n_tests = 0;
		repeat (8) @(posedge mclk);
		#1 check({faultOutputPinN, motorBlockedFaultN, bridgeEnable, openLoad, shortedLoad}, 32'hf0);
		@(posedge mclk);
		reset_n <= 1'b1;
		// Reset values and refused accesses
		apb(1'b0, ADDR_CONFIG, 32'h0);
		check(rd, 32'h00001000);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		check(err, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'hffffffff);
		check(err, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h00018000);
		// Table of temperature and short cases
		foreach (ROWS[i]) begin
			apb(1'b1, ADDR_CONFIG, {16'h0, ROWS[i].cfg});
			@(posedge mclk);
			{overTemp, hotWarn} <= ROWS[i].temp;
			setOc(ROWS[i].low, ROWS[i].high);
			repeat (ROWS[i].cyc - 1) @(posedge mclk);
			#1 check(bridgeEnable, 2'h3);
			@(posedge mclk);
			#1 check(bridgeEnable, ROWS[i].bridge);
			check(faultOutputPinN, ROWS[i].fault);
			check(shortedLoad, ROWS[i].sl);
			releaseFaults();
		end
		// Overcurrent gone one cycle before expiry: no latch
		@(posedge mclk);
		setOc(4'h1, 4'h0);
		repeat (199) @(posedge mclk);
		setOc(4'h0, 4'h0);
		repeat (2) @(posedge mclk);
		#1 check(bridgeEnable, 2'h3);
		// Persistent short retried at each step edge
		@(posedge mclk);
		setOc(4'h1, 4'h0);
		for (int k = 0; k < 2; k++) begin
			waitBridge(2'h2);
			check(32'(n >= 195 && n <= 205), 32'h1);
			@(posedge mclk);
			stepReq <= 1'b1;
			@(posedge mclk);
			stepReq <= 1'b0;
			waitBridge(2'h3);
			check(32'(n < 5), 32'h1);
		end
		releaseFaults();
		// Open load: sixteen missed cycles, then release by DAC
		@(posedge mclk);
		phaseDac[0] <= 6'h20;
		pulse(0, 15, 360);
		#1 check(openLoad, 2'h0);
		pulse(0, 1, 360);
		#1 check(openLoad, 2'h1);
		check(bridgeEnable, 2'h3);
		@(posedge mclk);
		phaseDac[0] <= 6'h1f;
		repeat (2) @(posedge mclk);
		#1 check(openLoad, 2'h0);
		// Thirty percent level chosen, twenty percent current is not enough
		apb(1'b1, ADDR_CONFIG, 32'h00001004);
		phaseDac[0] <= 6'h20;
		aboveOl20[0] <= 1'b1;
		pulse(0, 16, 360);
		#1 check(openLoad, 2'h1);
		@(posedge mclk);
		aboveOl30[0] <= 1'b1;
		pulse(0, 2, 360);
		#1 check(openLoad, 2'h0);
		// Cycles shorter than the blank time never see the current
		// First short cycle still carries the last full cycle's sighting
		pulse(0, 17, 100);
		#1 check(openLoad, 2'h1);
		// Short blank with the twenty percent level sees the current again
		@(posedge mclk);
		aboveOl30[0] <= 1'b0;
		apb(1'b1, ADDR_CONFIG, 32'h00001001);
		pulse(0, 1, 200);
		#1 check(openLoad, 2'h0);
		@(posedge mclk);
		phaseDac[0] <= 6'h00;
		// Stall compare with margin two
		apb(1'b1, ADDR_CONFIG, 32'h00001020);
		rise(0, 3);
		check(motorBlockedFaultN, 1'b0);
		rise(1, 5);
		check(motorBlockedFaultN, 1'b1);
		rise(0, 8);
		check(motorBlockedFaultN, 1'b0);
		apb(1'b0, ADDR_COUNT, 32'h0);
		check(rd[15:0], 16'h0508);
		apb(1'b1, ADDR_CONFIG, 32'h00001000);
		rise(1, 0);
		check(motorBlockedFaultN, 1'b1);
		rise(0, 300);
		apb(1'b0, ADDR_COUNT, 32'h0);
		check(rd[7:0], 8'hff);
		rise(0, 2);
		apb(1'b0, ADDR_COUNT, 32'h0);
		check(rd[7:0], 8'h02);
		// Reset in mid-run: standing faults and configuration dropped at once
		@(posedge mclk);
		{overTemp, hotWarn} <= 2'h3;
		apb(1'b1, ADDR_CONFIG, 32'h00000007);
		#1 check(bridgeEnable, 2'h0);
		@(posedge mclk);
		reset_n <= 1'b0;
		#1 check({faultOutputPinN, motorBlockedFaultN, bridgeEnable, openLoad, shortedLoad}, 32'hf0);
		repeat (2) @(posedge mclk);
		{overTemp, hotWarn} <= 2'h0;
		reset_n <= 1'b1;
		apb(1'b0, ADDR_CONFIG, 32'h0);
		check(rd, 32'h00001000);
		results();
	end
endmodule

`default_nettype wire
